// *** common/flash_status_pkg.sv ***
package flash_status_pkg;
   // Status bit positions on the flash data bus
   localparam int unsigned POLL_BIT = 7;
   localparam int unsigned TOGGLE1_BIT = 6;
   localparam int unsigned LIMIT_BIT = 5;
   localparam int unsigned TIMER_BIT = 3;
   localparam int unsigned TOGGLE2_BIT = 2;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 20;

   // APB register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_IRQ = 8'h10;
   localparam logic [7:0] REG_MASK = 8'h14;
   localparam logic [7:0] REG_RDATA = 8'h18;

   // Control register commands (write-one pulses)
   localparam int unsigned CTRL_POLL = 0;
   localparam int unsigned CTRL_RESET = 1;
   localparam int unsigned CTRL_WRITE = 2;
   localparam int unsigned CTRL_READ = 3;

   // Interrupt bits
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_FAIL = 1;
   localparam int unsigned IRQ_TIMER = 2;
   localparam int unsigned IRQ_W = 3;

   // Reset command written to the device
   localparam logic [15:0] RESET_CMD = 16'h00f0;

   // Bus cycle timing at 10 MHz
   localparam int unsigned CLK_NS = 100;
   localparam int unsigned ACCESS_NS = 200;
   localparam logic [3:0] ACCESS_CYC =
      4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
   // Extra cycles covering the two-stage data synchroniser
   localparam logic [3:0] SYNC_CYC = 4'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ1 = 3'b001,
      ST_READ2 = 3'b010,
      ST_RECHECK = 3'b011,
      ST_RESET = 3'b100,
      ST_WRITE = 3'b101,
      ST_READ = 3'b110
   } poll_state_e;
endpackage

// *** hw/flash_bus_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
// One asynchronous read or write cycle on the flash pins
module flash_bus_cycle (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic wr,
   input wire logic [flash_status_pkg::ADDR_W-1:0] addr,
   input wire logic [flash_status_pkg::DATA_W-1:0] wdata,
   input wire logic [flash_status_pkg::DATA_W-1:0] dq_sync,
   output logic done,
   output logic [flash_status_pkg::DATA_W-1:0] rdata,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [flash_status_pkg::ADDR_W-1:0] a_out,
   output logic [flash_status_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe
);
   logic [3:0] cnt_r;
   logic busy_r;
   logic wr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         wr_r <= 1'b0;
         done <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         a_out <= '0;
         dq_out <= '0;
         dq_oe <= 1'b0;
         rdata <= '0;
      end else begin
         done <= 1'b0;
         if (!busy_r && start) begin
            busy_r <= 1'b1;
            wr_r <= wr;
            cnt_r <= flash_status_pkg::ACCESS_CYC +
                     flash_status_pkg::SYNC_CYC;
            ce_n <= 1'b0;
            oe_n <= wr;
            we_n <= !wr;
            a_out <= addr;
            dq_out <= wdata;
            dq_oe <= wr;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
            // Data passed two synchroniser stages, so sample late
            if (cnt_r == 4'h1) begin
               busy_r <= 1'b0;
               done <= 1'b1;
               ce_n <= 1'b1;
               oe_n <= 1'b1;
               we_n <= 1'b1;
               dq_oe <= 1'b0;
               if (!wr_r) begin
                  rdata <= dq_sync;
               end
            end
         end
      end
   end
endmodule // flash_bus_cycle
`default_nettype wire

// *** hw/flash_status_host.sv ***
// Contract
// - Host writes reset command after failure; here only on a CTRL_RESET write, a failure just sets fail_r and IRQ_FAIL
// - Ignore timer only if spacing under 50us
// - Confirm acceptance before reading timer
// - Check timer before and after commands
// - Status reads use address in target sector
`timescale 1ns/1ps
`default_nettype none
module flash_status_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [flash_status_pkg::ADDR_W-1:0] flash_addr,
   output logic [flash_status_pkg::DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [flash_status_pkg::DATA_W-1:0] flash_dq_in,
   input wire logic ready_busy_n_in
);
   logic [flash_status_pkg::DATA_W-1:0] dq_s1_r, dq_s2_r;
   logic rb_s1_r, rb_s2_r;
   logic [flash_status_pkg::ADDR_W-1:0] addr_r;
   logic [flash_status_pkg::DATA_W-1:0] data_r, first_r, rdata_r;
   logic [flash_status_pkg::IRQ_W-1:0] irq_r, mask_r, ev_r;
   logic busy_r, fail_r, timer_r, prev_timer_r, rejected_r, suspended_r;
   flash_status_pkg::poll_state_e state_r;
   logic cyc_start, cyc_wr, cyc_done;
   logic [flash_status_pkg::DATA_W-1:0] cyc_wdata, cyc_rdata;
   logic wr_acc, ctrl_wr;

   function automatic logic toggled(input logic [15:0] a, input logic [15:0] b,
                                    input int unsigned bit_n);
      return a[bit_n] != b[bit_n];
   endfunction

   // Pins from outside pass two flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_s1_r <= '0;
         dq_s2_r <= '0;
         rb_s1_r <= 1'b1;
         rb_s2_r <= 1'b1;
      end else begin
         dq_s1_r <= flash_dq_in;
         dq_s2_r <= dq_s1_r;
         rb_s1_r <= ready_busy_n_in;
         rb_s2_r <= rb_s1_r;
      end
   end

   assign wr_acc = psel && penable && pwrite;
   assign ctrl_wr = wr_acc && (paddr == flash_status_pkg::REG_CTRL) &&
                    (state_r == flash_status_pkg::ST_IDLE);

   assign cyc_start = (state_r != flash_status_pkg::ST_IDLE) && !busy_r;
   assign cyc_wr = (state_r == flash_status_pkg::ST_RESET) ||
                   (state_r == flash_status_pkg::ST_WRITE);
   assign cyc_wdata = (state_r == flash_status_pkg::ST_RESET) ?
                      flash_status_pkg::RESET_CMD : data_r;

   flash_bus_cycle u_cycle (
      .pclk(pclk),
      .presetn(presetn),
      .start(cyc_start),
      .wr(cyc_wr),
      .addr(addr_r),
      .wdata(cyc_wdata),
      .dq_sync(dq_s2_r),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .ce_n(flash_ce_n),
      .oe_n(flash_oe_n),
      .we_n(flash_we_n),
      .a_out(flash_addr),
      .dq_out(flash_dq_out),
      .dq_oe(flash_dq_oe)
   );

   // Status polling sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= flash_status_pkg::ST_IDLE;
         busy_r <= 1'b0;
         first_r <= '0;
         rdata_r <= '0;
         fail_r <= 1'b0;
         timer_r <= 1'b0;
         prev_timer_r <= 1'b0;
         rejected_r <= 1'b0;
         suspended_r <= 1'b0;
         ev_r <= '0;
      end else begin
         // Event pulses last one cycle, picked up by the sticky bits
         ev_r <= '0;
         if (cyc_start) begin
            busy_r <= 1'b1;
         end
         if (cyc_done) begin
            busy_r <= 1'b0;
         end
         case (state_r)
            flash_status_pkg::ST_IDLE: begin
               if (ctrl_wr && pwdata[flash_status_pkg::CTRL_RESET]) begin
                  state_r <= flash_status_pkg::ST_RESET;
               end else if (ctrl_wr && pwdata[flash_status_pkg::CTRL_WRITE]) begin
                  state_r <= flash_status_pkg::ST_WRITE;
               end else if (ctrl_wr && pwdata[flash_status_pkg::CTRL_READ]) begin
                  state_r <= flash_status_pkg::ST_READ;
               end else if (ctrl_wr && pwdata[flash_status_pkg::CTRL_POLL]) begin
                  prev_timer_r <= timer_r;
                  state_r <= flash_status_pkg::ST_READ1;
               end
            end
            flash_status_pkg::ST_READ1: begin
               if (cyc_done) begin
                  first_r <= cyc_rdata;
                  state_r <= flash_status_pkg::ST_READ2;
               end
            end
            flash_status_pkg::ST_READ2, flash_status_pkg::ST_RECHECK: begin
               if (cyc_done) begin
                  first_r <= cyc_rdata;
                  rdata_r <= cyc_rdata;
                  // timer bit trusted once toggle confirms acceptance
                  if (toggled(first_r, cyc_rdata,
                              flash_status_pkg::TOGGLE1_BIT)) begin
                     timer_r <= cyc_rdata[flash_status_pkg::TIMER_BIT];
                     rejected_r <= prev_timer_r &&
                        cyc_rdata[flash_status_pkg::TIMER_BIT];
                     suspended_r <= 1'b0;
                     if (state_r == flash_status_pkg::ST_RECHECK) begin
                        fail_r <= 1'b1;
                        ev_r[flash_status_pkg::IRQ_FAIL] <= 1'b1;
                        state_r <= flash_status_pkg::ST_IDLE;
                     end else if (cyc_rdata[flash_status_pkg::LIMIT_BIT]) begin
                        state_r <= flash_status_pkg::ST_RECHECK;
                     end else begin
                        state_r <= flash_status_pkg::ST_IDLE;
                     end
                     if (cyc_rdata[flash_status_pkg::TIMER_BIT] && !timer_r) begin
                        ev_r[flash_status_pkg::IRQ_TIMER] <= 1'b1;
                     end
                  end else begin
                     // no toggle one but toggle two moving = suspended
                     suspended_r <= toggled(first_r, cyc_rdata,
                                            flash_status_pkg::TOGGLE2_BIT);
                     timer_r <= 1'b0;
                     ev_r[flash_status_pkg::IRQ_DONE] <= 1'b1;
                     state_r <= flash_status_pkg::ST_IDLE;
                  end
               end
            end
            flash_status_pkg::ST_RESET: begin
               if (cyc_done) begin
                  fail_r <= 1'b0;
                  timer_r <= 1'b0;
                  state_r <= flash_status_pkg::ST_IDLE;
               end
            end
            flash_status_pkg::ST_WRITE: begin
               if (cyc_done) begin
                  state_r <= flash_status_pkg::ST_IDLE;
               end
            end
            flash_status_pkg::ST_READ: begin
               if (cyc_done) begin
                  rdata_r <= cyc_rdata;
                  state_r <= flash_status_pkg::ST_IDLE;
               end
            end
            default: state_r <= flash_status_pkg::ST_IDLE;
         endcase
      end
   end

   // Registers written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r <= '0;
         data_r <= '0;
         mask_r <= '0;
      end else if (wr_acc) begin
         if (paddr == flash_status_pkg::REG_ADDR) begin
            addr_r <= pwdata[flash_status_pkg::ADDR_W-1:0];
         end else if (paddr == flash_status_pkg::REG_DATA) begin
            data_r <= pwdata[flash_status_pkg::DATA_W-1:0];
         end else if (paddr == flash_status_pkg::REG_MASK) begin
            mask_r <= pwdata[flash_status_pkg::IRQ_W-1:0];
         end
      end
   end

   // Sticky interrupt bits, set wins over write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_acc && paddr == flash_status_pkg::REG_IRQ) begin
            irq_r <= (irq_r & ~pwdata[flash_status_pkg::IRQ_W-1:0]) | ev_r;
         end else begin
            irq_r <= irq_r | ev_r;
         end
         irq <= |(irq_r & mask_r);
      end
   end

   // APB read data, zero-wait slave
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            if (paddr == flash_status_pkg::REG_CTRL) begin
               prdata <= {29'h0, state_r};
            end else if (paddr == flash_status_pkg::REG_ADDR) begin
               prdata <= {12'h000, addr_r};
            end else if (paddr == flash_status_pkg::REG_DATA) begin
               prdata <= {16'h0000, data_r};
            end else if (paddr == flash_status_pkg::REG_STATUS) begin
               prdata <= {26'h000_0000, suspended_r, rejected_r, timer_r,
                          fail_r, !rb_s2_r, state_r != flash_status_pkg::ST_IDLE};
            end else if (paddr == flash_status_pkg::REG_IRQ) begin
               prdata <= {29'h0, irq_r};
            end else if (paddr == flash_status_pkg::REG_MASK) begin
               prdata <= {29'h0, mask_r};
            end else if (paddr == flash_status_pkg::REG_RDATA) begin
               prdata <= {16'h0000, rdata_r};
            end else begin
               prdata <= '0;
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule // flash_status_host
`default_nettype wire

// *** verif/flash_status_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_status_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [flash_status_pkg::ADDR_W-1:0] flash_addr,
   input wire logic [flash_status_pkg::DATA_W-1:0] flash_dq_out,
   input wire logic flash_dq_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_read_low;
      (!flash_oe_n)[*4];
   endsequence
   sequence s_write_low;
      (!flash_we_n)[*4];
   endsequence
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("late pready");
   property p_slverr;
      pslverr |-> psel && penable && !pwrite && prdata == 32'h0;
   endproperty
   a_slverr: assert property (p_slverr) else $error("bad pslverr");
   property p_read_len;
      $fell(flash_oe_n) |-> s_read_low ##1 flash_oe_n;
   endproperty
   a_read_len: assert property (p_read_len) else $error("read len");
   property p_write_len;
      $fell(flash_we_n) |-> s_write_low ##1 flash_we_n;
   endproperty
   a_write_len: assert property (p_write_len) else $error("write len");
   property p_no_overlap;
      !flash_oe_n |-> flash_we_n && !flash_ce_n && !flash_dq_oe;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("overlap");
   property p_addr_hold;
      !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("addr");
   property p_dq_hold;
      !flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_out);
   endproperty
   a_dq_hold: assert property (p_dq_hold) else $error("dq moved");
   property p_irq_off;
      psel && penable && pwrite && paddr == flash_status_pkg::REG_MASK
         && pwdata == 32'h0 |-> ##2 !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq masked");
endmodule // flash_status_props
bind flash_status_host flash_status_props u_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
   .flash_dq_oe(flash_dq_oe));
`default_nettype wire

// *** verif/flash_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Modes: 0 read, 1 program, 2 erase, 3 failed, 4 suspend, 5 timer window
module flash_dev_model (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [flash_status_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe,
   input wire logic load,
   input wire logic [2:0] new_mode,
   output logic [flash_status_pkg::DATA_W-1:0] dq_in,
   output logic ry_n
);
   logic [2:0] mode = 3'd0;
   logic [15:0] arr = 16'h0000;
   logic [15:0] last = 16'h0000;
   logic [15:0] st;
   logic t1 = 1'b0;
   logic t2 = 1'b0;
   always @(posedge we_n or posedge load) begin
      // Enable drops on the same edge as the strobe, so data alone counts
      if (load) mode <= new_mode;
      else if (dq_out == flash_status_pkg::RESET_CMD)
         mode <= 3'd0;
      else if (mode == 3'd0) arr <= dq_out;
   end
   always @(posedge oe_n) begin
      last <= st;
      if (mode != 3'd0 && mode != 3'd4) t1 <= ~t1;
      if (mode == 3'd2 || mode >= 3'd4) t2 <= ~t2;
   end
   always_comb begin
      st = 16'h0000;
      if (mode == 3'd0) st = arr;
      else st[flash_status_pkg::TOGGLE1_BIT] = t1;
      if (mode == 3'd1 || mode == 3'd3)
         st[flash_status_pkg::POLL_BIT] = ~arr[7];
      if (mode == 3'd3) st[flash_status_pkg::LIMIT_BIT] = 1'b1;
      if (mode == 3'd2) st[flash_status_pkg::TIMER_BIT] = 1'b1;
      if (mode == 3'd5) st[flash_status_pkg::TIMER_BIT] = 1'b0;
      if (mode == 3'd4) st[flash_status_pkg::POLL_BIT] = 1'b1;
      if (mode == 3'd2 || mode >= 3'd4)
         st[flash_status_pkg::TOGGLE2_BIT] = t2;
   end
   assign dq_in = (!ce_n && !oe_n) ? st : ~last;
   assign ry_n = (mode == 3'd0 || mode == 3'd4);
endmodule // flash_dev_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {logic [31:0] v; logic [31:0] m;} note_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv, d;
   logic ce_n, oe_n, we_n, dq_oe, ry_n, load;
   logic [2:0] new_mode;
   logic [flash_status_pkg::ADDR_W-1:0] fa;
   logic [flash_status_pkg::DATA_W-1:0] dq_o, dq_i;
   note_s q[$];
   note_s nt;
   int fail_count, n_tests, cyc, seed;
   logic [2:0] md [4] = '{3'd5, 3'd2, 3'd4, 3'd1};
   logic [31:0] sm [4] = '{32'h8, 32'h8, 32'h22, 32'h6};
   logic [31:0] se [4] = '{32'h0, 32'h8, 32'h20, 32'h2};
   flash_status_host u_flash_status_host (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_addr(fa), .flash_dq_out(dq_o),
      .flash_dq_oe(dq_oe), .flash_dq_in(dq_i), .ready_busy_n_in(ry_n));
   flash_dev_model u_flash_dev_model (.ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .dq_out(dq_o), .dq_oe(dq_oe), .load(load),
      .new_mode(new_mode), .dq_in(dq_i), .ry_n(ry_n));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic print_verdict;
      $display("tests=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, input logic [31:0] e, input logic [31:0] m);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      if (!w) q.push_back('{e, m});
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v, 32'h0, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      apb(1'b0, a, 32'h0, e, m);
   endtask
   task automatic wait_idle;
      int i;
      i = 0;
      do begin
         rd(flash_status_pkg::REG_CTRL, 32'h0, 32'h0);
         i++;
      end while (rv !== 32'h0 && i < 100);
      check(rv, 32'h0);
   endtask
   task automatic cmd(input logic [2:0] m, input int unsigned b);
      @(posedge pclk);
      new_mode <= m;
      load <= (m != 3'd7);
      @(posedge pclk);
      load <= 1'b0;
      wr(flash_status_pkg::REG_CTRL, 32'h1 << b);
      wait_idle();
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && q.size() > 0) begin
         nt = q.pop_front();
         if (nt.m != 32'h0) check(prdata & nt.m, nt.v & nt.m);
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      {psel, penable, pwrite, load, presetn} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      new_mode = 3'd0;
      seed = 75229;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0, 32'hffff_fff5);
      check({31'h0, slv}, 32'h1);
      d = $random(seed);
      wr(flash_status_pkg::REG_ADDR, d);
      rd(flash_status_pkg::REG_ADDR, d, 32'hf_ffff);
      d = $random(seed);
      // Keep the word apart from the reset command
      d[15] = 1'b1;
      wr(flash_status_pkg::REG_DATA, d);
      cmd(3'd7, flash_status_pkg::CTRL_WRITE);
      cmd(3'd7, flash_status_pkg::CTRL_READ);
      rd(flash_status_pkg::REG_RDATA, d, 32'hffff);
      for (int i = 0; i < 4; i++) begin
         cmd(md[i], flash_status_pkg::CTRL_POLL);
         rd(flash_status_pkg::REG_STATUS, se[i], sm[i]);
      end
      rd(flash_status_pkg::REG_IRQ, 32'h4, 32'h4);
      cmd(3'd3, flash_status_pkg::CTRL_POLL);
      rd(flash_status_pkg::REG_STATUS, 32'h4, 32'h4);
      rd(flash_status_pkg::REG_IRQ, 32'h2, 32'h2);
      wr(flash_status_pkg::REG_MASK, 32'h2);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      wr(flash_status_pkg::REG_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      wr(flash_status_pkg::REG_IRQ, 32'h2);
      rd(flash_status_pkg::REG_IRQ, 32'h0, 32'h2);
      rd(flash_status_pkg::REG_STATUS, 32'h4, 32'h4);
      cmd(3'd7, flash_status_pkg::CTRL_RESET);
      rd(flash_status_pkg::REG_STATUS, 32'h0, 32'h6);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(flash_status_pkg::REG_IRQ, 32'h0, 32'hffff_ffff);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
